// ---- core/icm_pkg.sv ----
// package for the input change monitor: widths, timing, carriers
// assumes a single 100 MHz clock domain
package icm_pkg;
  localparam int          ICM_NUM_IN      = 8;
  localparam int          ICM_NUM_OUT     = 16;
  localparam int          ICM_CLK_HZ      = 100_000_000;
  // sampling rate must exceed 1 kHz; chosen 10 kHz
  localparam int          ICM_SAMPLE_HZ   = 10_000;
  localparam int          ICM_SAMPLE_DIV  = ICM_CLK_HZ / ICM_SAMPLE_HZ;
  localparam logic [7:0]  ICM_MASK_RST    = 8'h00;
  localparam logic [15:0] ICM_OUT_RST     = 16'h0000;

  typedef struct packed {
    logic [ICM_NUM_IN-1:0] pos_mask;
    logic [ICM_NUM_IN-1:0] neg_mask;
    logic [ICM_NUM_IN-1:0] enable;
  } icm_cfg_s;

  typedef enum logic [1:0] {
    ICM_ST_HOLD  = 2'b00,
    ICM_ST_LOAD  = 2'b01,
    ICM_ST_RUN   = 2'b10
  } icm_state_e;
endpackage

// ---- core/icm_sampler.sv ----
// three-stage synchroniser plus sample-enable divider and edge detector
// assumes raw inputs are asynchronous pins
`timescale 1ns/10ps
module icm_sampler
  import icm_pkg::*;
#(
  parameter int W   = ICM_NUM_IN,
  parameter int DIV = ICM_SAMPLE_DIV
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_ff,
  output logic      [W-1:0] rise_ff,
  output logic      [W-1:0] fall_ff
);
  logic [W-1:0]  s1_ff;
  logic [W-1:0]  s2_ff;
  logic [W-1:0]  s3_ff;
  logic [W-1:0]  prev_ff;
  logic [15:0]   div_ff;
  logic          tick;
  logic          primed_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // accepted level changes only where stage two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_ff <= '0;
    end else begin
      level_ff <= (s2_ff & s3_ff) | (level_ff & (s2_ff | s3_ff)); // [R8]
    end
  end

  assign tick = (div_ff == 16'(DIV - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= '0;
    end else if (tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end

  // first tick after reset only primes the previous sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      primed_ff <= 1'b0;
    end else if (tick) begin
      primed_ff <= 1'b1;
    end
  end

  // compare sample with previous sample of the same input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= '0;
      rise_ff <= '0;
      fall_ff <= '0;
    end else if (tick) begin
      prev_ff <= level_ff; // [R1]
      rise_ff <= primed_ff ? (level_ff & ~prev_ff) : '0; // [R8]
      fall_ff <= primed_ff ? (~level_ff & prev_ff) : '0; // [R8]
    end else begin
      rise_ff <= '0;
      fall_ff <= '0;
    end
  end
endmodule

// ---- core/icm_top.sv ----
// input change monitor with output power-on gating
// assumes config and read strobes come from logic on the same clock
// What this block does
// [R1] sample inputs above 1 kHz; latch rise/fall per positive/negative masks
// [R2] enabled event bits form summary bit, raising service request
// [R3] condition read gives live levels; event read gives qualified changes
// [R4] outputs held off after power-on until stored configuration loaded
// [R5] relay enable output stays inactive while outputs held off
// [R6] event register accumulates since last read; read returns then clears
// [R7] eight inputs, same bit order in all views
// [R8] three-stage synchroniser, then compare sample with previous sample
`timescale 1ns/10ps
module icm_top
  import icm_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [ICM_NUM_IN-1:0]  din,
  input  wire icm_cfg_s               cfg,
  input  wire logic                   evt_rd,
  input  wire logic                   cond_rd,
  input  wire logic [ICM_NUM_OUT-1:0] out_data,
  input  wire logic                   out_load,
  output logic [ICM_NUM_IN-1:0]       cond_ff,
  output logic [ICM_NUM_IN-1:0]       evt_data_ff,
  output logic                        rd_valid_ff,
  output logic                        summary_ff,
  output logic                        srq_ff,
  output logic [ICM_NUM_OUT-1:0]      out_drv_ff,
  output logic                        out_en_ff,
  output icm_state_e                  state_ff
);
  logic [ICM_NUM_IN-1:0]  level;
  logic [ICM_NUM_IN-1:0]  rise;
  logic [ICM_NUM_IN-1:0]  fall;
  logic [ICM_NUM_IN-1:0]  evt_ff;
  logic [ICM_NUM_IN-1:0]  hit;
  logic [ICM_NUM_IN-1:0]  nxt_evt;
  logic [ICM_NUM_IN-1:0]  nxt_evt_data;
  logic [ICM_NUM_IN-1:0]  nxt_cond;
  logic                   nxt_rd_valid;
  logic                   nxt_summary;
  logic                   nxt_srq;
  logic [ICM_NUM_OUT-1:0] latch_ff;
  logic [ICM_NUM_OUT-1:0] nxt_latch;
  logic [ICM_NUM_OUT-1:0] nxt_out_drv;
  logic                   nxt_out_en;
  logic                   run;
  icm_state_e             nxt_state;

  // qualify raw edges through the transition masks
  function automatic logic [ICM_NUM_IN-1:0] qualify(
    input logic [ICM_NUM_IN-1:0] up,
    input logic [ICM_NUM_IN-1:0] down,
    input logic [ICM_NUM_IN-1:0] up_mask,
    input logic [ICM_NUM_IN-1:0] down_mask
  );
    qualify = (up & up_mask) | (down & down_mask);
  endfunction

  // true when any latched event is enabled
  function automatic logic any_enabled(
    input logic [ICM_NUM_IN-1:0] events,
    input logic [ICM_NUM_IN-1:0] enables
  );
    any_enabled = |(events & enables);
  endfunction

  // synchronise, sample and detect edges
  icm_sampler #(
    .W   (ICM_NUM_IN),
    .DIV (ICM_SAMPLE_DIV)
  ) u_smp (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin_in   (din),
    .level_ff (level),
    .rise_ff  (rise),
    .fall_ff  (fall)
  );

  assign hit = qualify(rise, fall, cfg.pos_mask, cfg.neg_mask); // [R1]

  // accumulate events; a read clears, but a same-cycle set wins
  always_comb begin
    nxt_evt = evt_ff | hit; // [R6]
    if (evt_rd) begin
      nxt_evt = hit; // [R6]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_ff <= ICM_MASK_RST;
    end else begin
      evt_ff <= nxt_evt;
    end
  end

  // event view snapshot, held until the next event read
  always_comb begin
    nxt_evt_data = evt_data_ff;
    if (evt_rd) begin
      nxt_evt_data = evt_ff; // [R3] [R7]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_data_ff <= ICM_MASK_RST;
    end else begin
      evt_data_ff <= nxt_evt_data;
    end
  end

  // condition view snapshot of live levels
  always_comb begin
    nxt_cond = cond_ff;
    if (cond_rd) begin
      nxt_cond = level; // [R3] [R7]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_ff <= ICM_MASK_RST;
    end else begin
      cond_ff <= nxt_cond;
    end
  end

  // one-cycle echo of any read strobe
  always_comb begin
    nxt_rd_valid = evt_rd | cond_rd;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  // summary level and request pulse on its rise
  always_comb begin
    nxt_summary = any_enabled(evt_ff, cfg.enable); // [R2]
    nxt_srq     = any_enabled(evt_ff, cfg.enable) & ~summary_ff; // [R2]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      summary_ff <= 1'b0;
    end else begin
      summary_ff <= nxt_summary;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srq_ff <= 1'b0;
    end else begin
      srq_ff <= nxt_srq;
    end
  end

  // output gating sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ICM_ST_HOLD: begin
        if (out_load) begin
          nxt_state = ICM_ST_LOAD;
        end
      end
      ICM_ST_LOAD: nxt_state = ICM_ST_RUN;
      ICM_ST_RUN:  nxt_state = ICM_ST_RUN;
      default:     nxt_state = ICM_ST_HOLD;
    endcase
  end

  // sequencer state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ICM_ST_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // output latches, reloadable at any time
  always_comb begin
    nxt_latch = latch_ff;
    if (out_load) begin
      nxt_latch = out_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_ff <= ICM_OUT_RST;
    end else begin
      latch_ff <= nxt_latch;
    end
  end

  // drivers and relay enable stay off until the sequencer reaches run
  assign run         = (state_ff == ICM_ST_RUN);
  assign nxt_out_drv = run ? latch_ff : ICM_OUT_RST; // [R4]
  assign nxt_out_en  = run; // [R5]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_drv_ff <= ICM_OUT_RST;
    end else begin
      out_drv_ff <= nxt_out_drv;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_en_ff <= 1'b0;
    end else begin
      out_en_ff <= nxt_out_en;
    end
  end
endmodule

// ---- verif/icm_top_sva.sv ----
// checker for the input change monitor top ports
// assumes one clock domain, reset async active low
`timescale 1ns/10ps
module icm_top_sva
  import icm_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire icm_cfg_s               cfg,
  input wire logic                   evt_rd,
  input wire logic                   cond_rd,
  input wire logic                   out_load,
  input wire logic                   rd_valid_ff,
  input wire logic                   summary_ff,
  input wire logic                   srq_ff,
  input wire logic [ICM_NUM_OUT-1:0] out_drv_ff,
  input wire logic                   out_en_ff,
  input wire icm_state_e             state_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_en_run: assert property (out_en_ff |-> state_ff == ICM_ST_RUN)
    else $error("enable outside run");
  chk_drv_off: assert property (!out_en_ff |-> out_drv_ff == 16'h0000)
    else $error("outputs driven while held");
  chk_en_stays: assert property (out_en_ff |=> out_en_ff)
    else $error("enable dropped");
  chk_load_en: assert property (out_load |-> ##[1:3] out_en_ff)
    else $error("load did not enable");
  chk_rd_pulse: assert property ((evt_rd || cond_rd) |=> rd_valid_ff
    ##1 (!rd_valid_ff || $past(evt_rd || cond_rd)))
    else $error("read valid missing");
  chk_rd_idle: assert property (!(evt_rd || cond_rd) |=> !rd_valid_ff)
    else $error("spurious read valid");
  chk_srq_rise: assert property (srq_ff |-> $rose(summary_ff))
    else $error("request without summary rise");
  chk_sum_mask: assert property (cfg.enable == 8'h00 |=> !summary_ff)
    else $error("summary with no enables");
  chk_srq_pulse: assert property (srq_ff |=> !srq_ff)
    else $error("request longer than one cycle");
endmodule
bind icm_top icm_top_sva chk_u (.clk, .rst_n, .cfg, .evt_rd, .cond_rd, .out_load,
  .rd_valid_ff, .summary_ff, .srq_ff, .out_drv_ff, .out_en_ff, .state_ff);

// ---- verif/icm_host.sv ----
// host side model: counts service requests
// assumes request is a one-cycle pulse
`timescale 1ns/10ps
module icm_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic srq_ff,
  output int       srq_cnt
);
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) srq_cnt <= 0;
    else if (srq_ff) srq_cnt <= srq_cnt + 1;
endmodule

// ---- verif/tb_input_change_monitor.sv ----
// testbench for the input change monitor
// assumes sample tick every ICM_SAMPLE_DIV cycles
`timescale 1ns/10ps
module tb_input_change_monitor;
  import icm_pkg::*;
  logic clk = 0, rst_n = 0, evt_rd = 0, cond_rd = 0, out_load = 0;
  logic [7:0] din = 8'h00, cond_ff, evt_data_ff;
  logic [15:0] out_data = 16'h0000, out_drv_ff;
  logic rd_valid_ff, summary_ff, srq_ff, out_en_ff;
  icm_cfg_s cfg = '0;
  icm_state_e state_ff;
  int failures = 0, compares = 0, cyc = 0, srq_cnt;
  icm_top dut_u (.clk, .rst_n, .din, .cfg, .evt_rd, .cond_rd, .out_data, .out_load,
    .cond_ff, .evt_data_ff, .rd_valid_ff, .summary_ff, .srq_ff, .out_drv_ff,
    .out_en_ff, .state_ff);
  icm_host host_u (.clk, .rst_n, .srq_ff, .srq_cnt);
  initial forever #5 clk = ~clk;
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rd(input logic e, input logic [7:0] x);
    evt_rd = e;
    cond_rd = !e;
    step(1);
    evt_rd = 0;
    cond_rd = 0;
    cmp(16'(rd_valid_ff), 16'h0001);
    cmp(16'(e ? evt_data_ff : cond_ff), 16'(x));
    step(1);
  endtask
  task results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      results();
    end
  end
  initial begin
    step(10);
    rst_n = 1;
    cmp(out_drv_ff, 16'h0000);
    cmp(16'(out_en_ff), 16'h0000);
    cfg = '{8'h8F, 8'hF0, 8'h01};
    step(10020);
    din = 8'hFF;
    step(10020);
    cmp(16'(summary_ff), 16'h0001);
    rd(1, 8'h8F);
    rd(1, 8'h00);
    rd(0, 8'hFF);
    cmp(16'(srq_cnt), 16'h0001);
    $display("rise test done");
    din = 8'h00;
    step(10020);
    rd(1, 8'hF0);
    rd(0, 8'h00);
    $display("fall test done");
    cfg.enable = 8'h00;
    din = 8'h01;
    step(10020);
    din = 8'h03;
    step(10020);
    cmp(16'(summary_ff), 16'h0000);
    cfg.enable = 8'h02;
    step(2);
    cmp(16'(summary_ff), 16'h0001);
    cmp(16'(srq_cnt), 16'h0002);
    rd(1, 8'h03);
    rd(0, 8'h03);
    $display("accumulate test done");
    cmp(out_drv_ff, 16'h0000);
    cmp(16'(out_en_ff), 16'h0000);
    out_data = 16'hBEEF;
    out_load = 1;
    step(1);
    out_load = 0;
    step(3);
    cmp(out_drv_ff, 16'hBEEF);
    cmp(16'(out_en_ff), 16'h0001);
    cmp(16'(state_ff), 16'(ICM_ST_RUN));
    $display("load test done");
    results();
  end
endmodule
